/* core/spc_consts.vh */
// constants for the sector protection control block
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH
`define SPC_PREFIX_B0 8'h3D
`define SPC_PREFIX_B1 8'h2A
`define SPC_PREFIX_B2 8'h7F
`define SPC_OP_ERASE 8'hCF
`define SPC_OP_PROG 8'hFC
`define SPC_OP_ENABLE 8'hA9
`define SPC_OP_DISABLE 8'h9A
`define SPC_MAP_RESET 64'h0000_0000_0000_0000
`define SPC_MAP_ERASED 64'hFFFF_FFFF_FFFF_FFFF
`define SPC_BYTE_ON 8'hFF
`define SPC_SUB0A_HI 7
`define SPC_SUB0A_LO 6
`define SPC_SUB0B_HI 5
`define SPC_SUB0B_LO 4
`define SPC_CLK_MHZ 125
`define SPC_ERASE_TIME_US 100
`define SPC_PROG_TIME_US 100
`define SPC_WPE_DELAY_NS 1000
`define SPC_WPD_DELAY_NS 1000
`define SPC_WP_FILTER_NS 200
`endif

/* core/spc_protect.v */
// sector protection control: spi command decode, wp filter, map store
`timescale 1ns/1ps
`include "spc_consts.vh"

// how a frame is handled:
// - the host pulls chip select low, clocks the three prefix bytes and an
//   opcode msb first, optionally data bytes, then releases chip select
// - every pin is resampled on clk_sys, so a link clock edge is seen about
//   three system clocks late; the link clock must stay below an eighth of
//   clk_sys, which an 80 ns period meets
// - no command is acted on until chip select rises, so a frame cut inside
//   its first four bytes leaves the byte counter short and is dropped with no side effect
// - erase, enable and disable need exactly four bytes; program takes the
//   opcode plus data, and data past eight bytes wraps to map byte zero
// - program data lands in buffer 1 as it arrives, so buffer 1 is lost even
//   if the program is refused at chip select rise
// - erase and program are self timed; a frame sent meanwhile is shifted in
//   and its command dropped, but program data in it still overwrites buffer 1,
//   which a running program then writes to the map, so the host has to watch
//   busy before the next one
// - the timer counts system clocks, so its length scales with clk_sys
// write protect pin:
// - filtered against glitches, then forces protection on for every sector
//   the map marks, and keeps erase and program from starting, so only one already running can change the map
// - it never writes the software flag, so releasing the pin falls back to
//   whatever the enable and disable commands left there
// limitations:
// - the map is held in flops; keeping it across power loss is up to the
//   cell array outside this block
// - an invalid map byte simply reads as unprotected

module spc_protect #(
    parameter ERASE_CYCLES = `SPC_ERASE_TIME_US * `SPC_CLK_MHZ,
    parameter PROG_CYCLES = `SPC_PROG_TIME_US * `SPC_CLK_MHZ
) (
    input wire clk_sys,
    input wire rst_n,
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_si,
    input wire wp_n,
    input wire [2:0] wr_sector,
    input wire wr_page_hi,
    output reg busy_reg,
    output reg prot_enabled_reg,
    output reg sector_locked_reg,
    output reg [63:0] sector_protect_map_reg,
    output reg [63:0] buffer1_reg
);
    // timing budget: 2 clk sync, filter window, 1 clk output flop; the
    // filter window is capped by both wp delays so the pin acts in time
    localparam integer WPE_CYC = (`SPC_WPE_DELAY_NS * `SPC_CLK_MHZ) / 1000;
    localparam integer WPD_CYC = (`SPC_WPD_DELAY_NS * `SPC_CLK_MHZ) / 1000;
    localparam integer FILT_CYC = (`SPC_WP_FILTER_NS * `SPC_CLK_MHZ + 999) / 1000;
    localparam integer FILT_MIN = (FILT_CYC < WPE_CYC) ? FILT_CYC : WPE_CYC;
    localparam integer FILT_LIM = (FILT_MIN < WPD_CYC) ? FILT_MIN : WPD_CYC;
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_ERASE = 2'd1;
    localparam [1:0] ST_PROG = 2'd2;
    // pend codes after the opcode byte; code 1 also means prefix good so far
    localparam [1:0] PEND_NONE = 2'd0;
    localparam [1:0] PEND_ERASE = 2'd1;
    localparam [1:0] PEND_PROG = 2'd2;
    localparam [1:0] PEND_ENABLE = 2'd3;

    // pin synchroniser stages; the d stages feed the edge detectors
    reg sck_m_reg;
    reg sck_s_reg;
    reg sck_d_reg;
    reg cs_m_reg;
    reg cs_s_reg;
    reg cs_d_reg;
    reg si_m_reg;
    reg si_s_reg;
    reg wp_m_reg;
    reg wp_s_reg;

    reg wp_filt_reg;
    reg [7:0] filt_cnt_reg;
    reg sw_prot_reg;
    reg [7:0] shift_reg;
    reg [2:0] bit_cnt_reg;
    reg [4:0] byte_cnt_reg;
    reg [2:0] ptr_reg;
    reg [1:0] state_reg;
    reg [1:0] pend_reg;
    reg [31:0] timer_reg;
    reg sel_prot;

    // frame decode and map decode nets
    wire sck_rise;
    wire cs_rise;
    wire [7:0] byte_now;
    wire wp_on;
    wire map_wr_ok;
    wire [7:0] sector_prot_vec;
    wire sub0a_prot;
    wire sub0b_prot;
    wire cmd_erase;
    wire cmd_prog;
    wire cmd_enable;
    wire cmd_disable;
    wire timer_done;
    genvar g;

    // two-flop synchronisers for every pin input
    // reset values are the idle pin levels, so no false edge after reset
    // sck and cs keep a third flop for their edge detect
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sck_m_reg <= 1'b0;
            sck_s_reg <= 1'b0;
            sck_d_reg <= 1'b0;
            cs_m_reg <= 1'b1;
            cs_s_reg <= 1'b1;
            cs_d_reg <= 1'b1;
            si_m_reg <= 1'b0;
            si_s_reg <= 1'b0;
            wp_m_reg <= 1'b1;
            wp_s_reg <= 1'b1;
        end else begin
            sck_m_reg <= spi_sck;
            sck_s_reg <= sck_m_reg;
            sck_d_reg <= sck_s_reg;
            cs_m_reg <= spi_cs_n;
            cs_s_reg <= cs_m_reg;
            cs_d_reg <= cs_s_reg;
            si_m_reg <= spi_si;
            si_s_reg <= si_m_reg;
            wp_m_reg <= wp_n;
            wp_s_reg <= wp_m_reg;
        end
    end

    // edge detect and shifter input, all from second-stage flops
    assign sck_rise = sck_s_reg & ~sck_d_reg & ~cs_s_reg;
    assign cs_rise = cs_s_reg & ~cs_d_reg;
    assign byte_now = {shift_reg[6:0], si_s_reg};
    assign wp_on = ~wp_filt_reg;
    assign map_wr_ok = ~wp_on;

    // wp must hold a new level for the filter window before it counts;
    // window stays well under the enable and disable delays
    // reset value is the released level, so the pin starts unprotected
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wp_filt_reg <= 1'b1;
            filt_cnt_reg <= 8'h00;
        end else if (wp_s_reg == wp_filt_reg) begin
            filt_cnt_reg <= 8'h00;
        end else if (filt_cnt_reg >= FILT_LIM[7:0]) begin
            wp_filt_reg <= wp_s_reg;
            filt_cnt_reg <= 8'h00;
        end else begin
            filt_cnt_reg <= filt_cnt_reg + 8'h01;
        end
    end

    // command shifter: prefix check, opcode latch, data bytes to buffer 1
    // byte counter saturates so an endless frame cannot wrap back to four
    // and pass for a short command
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 5'd0;
            ptr_reg <= 3'd0;
            pend_reg <= 2'd0;
            buffer1_reg <= 64'h0000_0000_0000_0000;
        end else if (cs_s_reg) begin
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 5'd0;
            ptr_reg <= 3'd0;
            if (cs_rise)
                pend_reg <= PEND_NONE;
        end else if (sck_rise) begin
            shift_reg <= byte_now;
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            if (bit_cnt_reg == 3'd7) begin
                if (byte_cnt_reg != 5'd31)
                    byte_cnt_reg <= byte_cnt_reg + 5'd1;
                case (byte_cnt_reg)
                    5'd0: pend_reg <= (byte_now == `SPC_PREFIX_B0) ? 2'd1 : 2'd0;
                    5'd1: if (byte_now != `SPC_PREFIX_B1) pend_reg <= 2'd0;
                    5'd2: if (byte_now != `SPC_PREFIX_B2) pend_reg <= 2'd0;
                    5'd3: begin
                        if (pend_reg != 2'd1)
                            pend_reg <= 2'd0;
                        else if (byte_now == `SPC_OP_ERASE)
                            pend_reg <= 2'd1;
                        else if (byte_now == `SPC_OP_PROG)
                            pend_reg <= 2'd2;
                        else if (byte_now == `SPC_OP_ENABLE)
                            pend_reg <= 2'd3;
                        else if (byte_now == `SPC_OP_DISABLE)
                            pend_reg <= 2'd0; // tracked in dis_pend_reg
                        else
                            pend_reg <= 2'd0;
                    end
                    default: begin
                        if (pend_reg == 2'd2) begin
                            buffer1_reg[ptr_reg*8 +: 8] <= byte_now;
                            ptr_reg <= ptr_reg + 3'd1;
                        end
                    end
                endcase
            end
        end
    end

    // disable opcode tracked apart since pend codes are full;
    // cleared with every deselect like the other frame state
    reg dis_pend_reg;
    always @(posedge clk_sys) begin
        if (!rst_n)
            dis_pend_reg <= 1'b0;
        else if (cs_s_reg)
            dis_pend_reg <= 1'b0;
        else if (sck_rise && bit_cnt_reg == 3'd7 && byte_cnt_reg == 5'd3)
            dis_pend_reg <= (pend_reg == 2'd1) && (byte_now == `SPC_OP_DISABLE);
    end

    // commands act only on chip select rise with the exact byte count;
    // program accepts four bytes or more, short data is the host's risk
    assign cmd_erase = cs_rise && (byte_cnt_reg == 5'd4) && (pend_reg == PEND_ERASE);
    assign cmd_prog = cs_rise && (byte_cnt_reg >= 5'd4) && (pend_reg == PEND_PROG);
    assign cmd_enable = cs_rise && (byte_cnt_reg == 5'd4) && (pend_reg == PEND_ENABLE);
    assign cmd_disable = cs_rise && (byte_cnt_reg == 5'd4) && dis_pend_reg;
    // last count of a self-timed operation
    assign timer_done = (timer_reg <= 32'h0000_0001);

    // software state, map store and self-timed operations
    // enable is taken even under wp: the pin never blocks it
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sw_prot_reg <= 1'b0;
            sector_protect_map_reg <= `SPC_MAP_RESET;
            state_reg <= ST_IDLE;
            timer_reg <= 32'h0000_0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // map commands need wp released; the software flag plays
                    // no part in whether erase or program is taken
                    if (cmd_erase && map_wr_ok) begin
                        state_reg <= ST_ERASE;
                        timer_reg <= ERASE_CYCLES;
                    end else if (cmd_prog && map_wr_ok) begin
                        state_reg <= ST_PROG;
                        timer_reg <= PROG_CYCLES;
                    end else if (cmd_enable) begin
                        sw_prot_reg <= 1'b1;
                    end else if (cmd_disable && map_wr_ok) begin
                        sw_prot_reg <= 1'b0;
                    end
                end
                ST_ERASE: begin
                    // commands arriving now fall through unhandled,
                    // so a second erase cannot restart the timer
                    if (timer_done) begin
                        sector_protect_map_reg <= `SPC_MAP_ERASED;
                        state_reg <= ST_IDLE;
                    end else begin
                        timer_reg <= timer_reg - 32'h0000_0001;
                    end
                end
                ST_PROG: begin
                    // buffer 1 already holds the wrapped data bytes
                    if (timer_done) begin
                        sector_protect_map_reg <= buffer1_reg;
                        state_reg <= ST_IDLE;
                    end else begin
                        timer_reg <= timer_reg - 32'h0000_0001;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // per-sector decode of the map; sectors one to seven need a full ff
    generate
        for (g = 1; g < 8; g = g + 1) begin : gen_sector
            assign sector_prot_vec[g] =
                (sector_protect_map_reg[g*8 +: 8] == `SPC_BYTE_ON);
        end
    endgenerate

    // sector zero splits in two halves; its low nibble is never read
    assign sector_prot_vec[0] = 1'b0;
    assign sub0a_prot = &sector_protect_map_reg[`SPC_SUB0A_HI:`SPC_SUB0A_LO];
    assign sub0b_prot = &sector_protect_map_reg[`SPC_SUB0B_HI:`SPC_SUB0B_LO];

    // lock for the sector under query; an invalid byte just reads unlocked
    always @* begin
        sel_prot = sector_prot_vec[wr_sector];
        if (wr_sector == 3'd0) begin
            if (wr_page_hi)
                sel_prot = sub0b_prot;
            else
                sel_prot = sub0a_prot;
        end
    end

    // registered outputs; wp ors in without touching software state
    // lock uses the same protection term so both outputs move together
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            prot_enabled_reg <= 1'b0;
            sector_locked_reg <= 1'b0;
        end else begin
            busy_reg <= (state_reg != ST_IDLE);
            prot_enabled_reg <= sw_prot_reg | wp_on;
            sector_locked_reg <= (sw_prot_reg | wp_on) & sel_prot;
        end
    end
endmodule

/* verification/spc_protect_properties.sv */
// port assertions for the sector protection control block
`timescale 1ns/1ps
module spc_protect_properties (
    input wire clk_sys,
    input wire rst_n,
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_si,
    input wire wp_n,
    input wire [2:0] wr_sector,
    input wire wr_page_hi,
    input wire busy_reg,
    input wire prot_enabled_reg,
    input wire sector_locked_reg,
    input wire [63:0] sector_protect_map_reg,
    input wire [63:0] buffer1_reg
);
    logic [7:0] wp_low_cnt;
    logic [7:0] sel_byte;
    logic exp_lock;
    // pin low time, saturating so long holds stay visible
    always @(posedge clk_sys) begin
        if (!rst_n || wp_n) wp_low_cnt <= 8'h00;
        else if (wp_low_cnt != 8'hFF) wp_low_cnt <= wp_low_cnt + 8'h01;
    end
    // lock expected from the current map; low nibble of byte 0 never matters
    assign sel_byte = sector_protect_map_reg[8 * wr_sector +: 8];
    assign exp_lock = prot_enabled_reg && (wr_sector != 3'h0 ? sel_byte == 8'hFF
                      : (wr_page_hi ? sel_byte[5:4] : sel_byte[7:6]) == 2'b11);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_reset_clears: assert property (disable iff (1'b0)
        !rst_n |=> !busy_reg && !prot_enabled_reg && sector_protect_map_reg == 64'h0)
        else $error("outputs not cleared by reset");
    a_wp_forces_on: assert property (wp_low_cnt >= 8'h82 |-> prot_enabled_reg)
        else $error("protection off with write protect held");
    a_wp_blocks_op: assert property (wp_low_cnt >= 8'h28 |-> !$rose(busy_reg))
        else $error("map operation started under write protect");
    a_busy_bounded: assert property ($rose(busy_reg) |-> busy_reg [*8] ##[1:16] !busy_reg)
        else $error("busy length out of range");
    a_busy_after_cs: assert property ($rose(busy_reg) |-> $past(spi_cs_n) && $past(spi_cs_n, 2))
        else $error("busy rose without chip select released");
    a_map_at_end: assert property ($changed(sector_protect_map_reg)
        |-> busy_reg ##1 !busy_reg)
        else $error("map changed outside end of operation");
    a_lock_follows: assert property ($stable({wr_sector, wr_page_hi, prot_enabled_reg,
        sector_protect_map_reg}) |-> sector_locked_reg == exp_lock)
        else $error("sector lock does not match map");
    a_buffer_quiet: assert property (spi_cs_n [*8] |-> $stable(buffer1_reg))
        else $error("buffer changed while deselected");
endmodule
bind spc_protect spc_protect_properties spc_protect_properties_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .wp_n(wp_n),
    .wr_sector(wr_sector), .wr_page_hi(wr_page_hi), .busy_reg(busy_reg),
    .prot_enabled_reg(prot_enabled_reg), .sector_locked_reg(sector_locked_reg),
    .sector_protect_map_reg(sector_protect_map_reg), .buffer1_reg(buffer1_reg));

/* verification/spc_host.sv */
// serial host model sending protection commands, mode 0, 80 ns clock
`timescale 1ns/1ps
module spc_host (
    input wire clk_sys,
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_si
);
    initial begin
        spi_sck = 0;
        spi_cs_n = 1;
        spi_si = 0;
    end
    // clock idles low between frames; data line inverted once deselected
    task automatic frame(input logic [7:0] q[$]);
        @(negedge clk_sys) spi_cs_n = 0;
        foreach (q[i]) for (int k = 7; k >= 0; k--) begin
            spi_si = q[i][k];
            repeat (5) @(negedge clk_sys);
            spi_sck = 1;
            repeat (5) @(negedge clk_sys);
            spi_sck = 0;
        end
        repeat (5) @(negedge clk_sys);
        spi_cs_n = 1;
        spi_si = ~spi_si;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

/* verification/tb_sector_protection_control.sv */
// self-checking bench for the sector protection control block
`timescale 1ns/1ps
module tb_sector_protection_control;
    logic clk_sys, rst_n, wp_n, wr_page_hi, spi_sck, spi_cs_n, spi_si;
    logic busy_reg, prot_enabled_reg, sector_locked_reg;
    logic [2:0] wr_sector;
    logic [63:0] sector_protect_map_reg, buffer1_reg, exp_map;
    logic [63:0] exp_q[$];
    logic [7:0] lfsr_val;
    int miscompares = 0;
    int n_checks = 0;
    spc_protect #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) spc_protect_inst (.clk_sys(clk_sys),
        .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .wp_n(wp_n),
        .wr_sector(wr_sector), .wr_page_hi(wr_page_hi), .busy_reg(busy_reg),
        .prot_enabled_reg(prot_enabled_reg), .sector_locked_reg(sector_locked_reg),
        .sector_protect_map_reg(sector_protect_map_reg), .buffer1_reg(buffer1_reg));
    spc_host spc_host_inst (.clk_sys(clk_sys), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_si(spi_si));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        n_checks++;
        if (e !== s) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one command frame; data bytes are random but always valid map values
    task automatic op(input logic [7:0] code, input int nd, input bit runs);
        logic [63:0] e;
        logic [7:0] q[$];
        e = (code == 8'hCF) ? {64{1'b1}} : exp_map;
        q = '{8'h3D, 8'h2A, 8'h7F, code};
        for (int i = 0; i < nd; i++) begin
            lfsr_val = lfsr(lfsr_val);
            q.push_back(i % 8 == 0 ? {{2{lfsr_val[0]}}, {2{lfsr_val[1]}}, lfsr_val[5:2]}
                : {8{lfsr_val[0]}});
            e[8 * (i % 8) +: 8] = q[4 + i];
        end
        if (runs) begin
            exp_map = e;
            exp_q.push_back(e);
        end
        spc_host_inst.frame(q);
        repeat (40) @(negedge clk_sys);
    endtask
    task automatic lk(input logic [2:0] s, input logic h, input logic e);
        wr_sector = s;
        wr_page_hi = h;
        repeat (3) @(negedge clk_sys);
        chk("locked", {63'h0, e}, {63'h0, sector_locked_reg});
    endtask
    // each end of a self-timed operation is matched with the oldest note
    always @(negedge busy_reg) if (rst_n) begin
        repeat (2) @(negedge clk_sys);
        if (exp_q.size() == 0) chk("stray busy", 0, 1);
        else chk("map", exp_q.pop_front(), sector_protect_map_reg);
    end
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    // cuts a hang well past the expected run of about 4400 cycles
    initial begin
        #400_000;
        miscompares++;
        end_of_test();
    end
    initial begin
        rst_n = 0; wp_n = 1; wr_sector = 0; wr_page_hi = 0; lfsr_val = 8'h5F; exp_map = 0;
        repeat (10) @(negedge clk_sys);
        rst_n = 1;
        repeat (4) @(negedge clk_sys);
        chk("map reset", 0, sector_protect_map_reg);
        chk("prot reset", 0, {63'h0, prot_enabled_reg});
        op(8'hCF, 0, 1);
        lk(3'h3, 0, 0);
        op(8'hA9, 0, 0);
        lk(3'h5, 0, 1);
        op(8'hFC, 9, 1);
        chk("buffer1", exp_map, buffer1_reg);
        for (int s = 0; s < 9; s++) lk(3'(s), s == 8, s == 0 ? exp_map[7]
            : s == 8 ? exp_map[5] : exp_map[8 * s]);
        op(8'h9A, 0, 0);
        chk("prot off", 0, {63'h0, prot_enabled_reg});
        $display("command test done");
        wp_n = 0;
        repeat (10) @(negedge clk_sys);
        wp_n = 1;
        repeat (60) @(negedge clk_sys);
        chk("wp glitch", 0, {63'h0, prot_enabled_reg});
        wp_n = 0;
        repeat (150) @(negedge clk_sys);
        chk("wp on", 1, {63'h0, prot_enabled_reg});
        op(8'hCF, 0, 0);
        chk("map kept", exp_map, sector_protect_map_reg);
        op(8'h9A, 0, 0);
        chk("wp disable", 1, {63'h0, prot_enabled_reg});
        wp_n = 1;
        repeat (150) @(negedge clk_sys);
        chk("wp off", 0, {63'h0, prot_enabled_reg});
        op(8'hA9, 0, 0);
        wp_n = 0;
        repeat (150) @(negedge clk_sys);
        wp_n = 1;
        repeat (150) @(negedge clk_sys);
        chk("prot kept", 1, {63'h0, prot_enabled_reg});
        op(8'h9A, 0, 0);
        chk("prot cleared", 0, {63'h0, prot_enabled_reg});
        $display("write protect test done");
        end_of_test();
    end
endmodule
